/* cpsel_pkg.sv */
// constants and types of the cam program select and clear-shift block
package cpsel_pkg;
	// register offsets (byte addresses, one word each)
	localparam logic [7:0] ADDR_CLR_EXT = 8'h00;
	localparam logic [7:0] ADDR_DEAD    = 8'h04;
	localparam logic [7:0] ADDR_CAMINFO = 8'h08;
	localparam logic [7:0] ADDR_CFG     = 8'h0c;
	localparam logic [7:0] ADDR_VIEW    = 8'h10;
	localparam logic [7:0] ADDR_STATUS  = 8'h14;
	localparam logic [7:0] ADDR_SPEED   = 8'h18;
	// field positions
	localparam int CFG_PARTIAL = 0;
	localparam int CFG_MANY    = 1;
	localparam int CFG_XFER    = 2;
	localparam int VIEW_KP_REQ = 2;
	localparam int VIEW_PROG_LSB = 4;
	localparam int VIEW_OUT_LSB  = 8;
	localparam int DEAD_SHIFT    = 10;
	// synchronised input bit positions
	localparam int IN_SEL0 = 0;
	localparam int IN_STB  = 4;
	localparam int IN_REL  = 5;
	localparam int IN_CNT  = 6;
	localparam int IN_CLR  = 7;
	// reset values
	localparam logic [4:0] OUT_RESET  = 5'h01;
	localparam logic [7:0] EXT_RESET  = 8'h00;
	// encoder increments per revolution, plain default
	localparam int INC_PER_REV = 360;
	localparam int SEC_PER_MIN = 60;
	// timing
	localparam int CLK_HZ       = 100_000_000;
	localparam int CYC_PER_MS   = CLK_HZ / 1000;
	localparam int FAST_MS      = 100;
	localparam int SLOW_MS      = 750;
	localparam int EDIT_MS      = 200;
	localparam int DEB_MS       = 1;
	localparam int SPEED_WIN_MS = 1000;
	localparam int FAST_CYC     = FAST_MS * CYC_PER_MS;
	localparam int SLOW_CYC     = SLOW_MS * CYC_PER_MS;
	localparam int EDIT_CYC     = EDIT_MS * CYC_PER_MS;
	localparam int DEB_CYC      = DEB_MS * CYC_PER_MS;
	localparam int SPEED_CYC    = SPEED_WIN_MS * CYC_PER_MS;
	localparam logic [1:0] DEB_STABLE = 2'h3;
	// display modes
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_PROG   = 2'b01,
		MODE_OUTPUT = 2'b10
	} cpsel_mode_e;
endpackage

/* cpsel_top.sv */
// cam program selection, programming release, clear-shift counter and display indication
//
// Contract
// - edits accepted only while release input high
// - active program restored after power-up
// - normal mode: position below 1 rpm, else speed; other modes: position
// - speed shows n in second digit
// - clear extension settable 0 to 255
// - effective extension minus dead-time distance, clamped
// - count extension increments, then reset next pulse
// - clear ending early resets counter at once
// - each clear reset restarts full extension wait
// - zero extension resets counter without delay
// - counter increments on count falling edge
// - output 1 dead time drives extension reduction
// - strobe rising edge adopts number, no confirmation
// - fast changeover only without partial/many cams
// - changeover 100 ms fast, 750 ms slow
// - fast changeover plus 200 ms after edit; keypad changeover gets no edit penalty
// - no changeover during upload or download
// - decimal point active, cam LEDs if cams
// - output selection starts at 1, dead LED
`timescale 1ns/1ps
module cpsel_top #(
	parameter int P_FAST_CYC  = cpsel_pkg::FAST_CYC,
	parameter int P_SLOW_CYC  = cpsel_pkg::SLOW_CYC,
	parameter int P_EDIT_CYC  = cpsel_pkg::EDIT_CYC,
	parameter int P_DEB_CYC   = cpsel_pkg::DEB_CYC,
	parameter int P_SPEED_CYC = cpsel_pkg::SPEED_CYC
) (
	input  wire logic        I_REF_CLK,      // system clock, 100 MHz
	input  wire logic        I_RST_N,        // async reset, active low
	input  wire logic [7:0]  I_ADDR,         // register byte address
	input  wire logic [31:0] I_WDATA,        // write data
	input  wire logic        I_WR,           // write strobe
	input  wire logic        I_RD,           // read strobe
	output logic      [31:0] O_RDATA,        // read data, cycle after read
	input  wire logic        I_SEL_W8,       // program_select_weight8 pin
	input  wire logic        I_SEL_W4,       // program_select_weight4 pin
	input  wire logic        I_SEL_W2,       // program_select_weight2 pin
	input  wire logic        I_SEL_W1,       // program_select_weight1 pin
	input  wire logic        I_CHG_STROBE,   // program_change_strobe pin
	input  wire logic        I_PROG_RELEASE, // programming release pin
	input  wire logic        I_COUNT,        // encoder counting pulse
	input  wire logic        I_CLEAR,        // encoder clear, active high
	input  wire logic [3:0]  I_NV_PROG,      // retained active program
	output logic      [3:0]  O_NV_PROG,      // program to retain
	output logic             O_NV_WE,        // retain strobe, one pulse
	output logic      [3:0]  O_ACT_PROG,     // active program
	output logic             O_CHG_BUSY,     // changeover running
	output logic      [15:0] O_POSITION,     // position counter
	output logic      [15:0] O_DISP_VALUE,   // value for the display
	output logic             O_SHOW_SPEED,   // display shows speed
	output logic             O_DIGIT2_N,     // n in second digit
	output logic             O_DP_MID,       // middle decimal point
	output logic             O_LED_ON,       // cam-edge LED on
	output logic             O_LED_OFF,      // cam-edge LED off
	output logic             O_LED_FUNC,     // function LED
	output logic      [4:0]  O_SHOW_OUT,     // output number shown
	output logic             O_EDIT_ENA      // edits accepted now
);
	typedef struct packed {
		logic [7:0]       sync1;
		logic [7:0]       sync2;
		logic [16:0]      tick_cnt;
		logic [5:0][1:0]  deb_cnt;
		logic [5:0]       deb;
		logic             strobe_q;
		logic             cnt_q;
		logic             clr_q;
		logic [15:0]      pos;
		logic [7:0]       remain;
		logic             waiting;
		logic [26:0]      win_cnt;
		logic [15:0]      edge_cnt;
		logic [15:0]      ips;
		logic [7:0]       clr_ext;
		logic [7:0]       dead1;
		logic [15:0]      cam_mask;
		logic [15:0]      dead_mask;
		logic             partial;
		logic             many_cams;
		logic             xfer_busy;
		cpsel_pkg::cpsel_mode_e mode;
		logic [3:0]       show_prog;
		logic [4:0]       show_out;
		logic [3:0]       act_prog;
		logic [3:0]       pend_prog;
		logic             chg_busy;
		logic [26:0]      chg_cnt;
		logic             edited;
		logic             loaded;
		logic             nv_we;
		logic [15:0]      disp;
		logic [4:0]       leds;
		logic [31:0]      rdata;
	} cpsel_state_s;

	cpsel_state_s q;
	cpsel_state_s next_q;

	logic [7:0]  pins;
	logic        cnt_fall;
	logic        clr_rise;
	logic        clr_fall;
	logic        clr_act;
	logic        release_ok;
	logic        strobe_rise;
	logic [23:0] dist_prod;
	logic [13:0] s_tot;
	logic [7:0]  eff_ext;
	logic [21:0] rpm_scaled;
	logic        above_1rpm;
	logic        fast_ok;
	logic        chg_start;

	assign pins = {I_CLEAR, I_COUNT, I_PROG_RELEASE, I_CHG_STROBE,
		I_SEL_W8, I_SEL_W4, I_SEL_W2, I_SEL_W1};

	// edges and qualified levels, all from second sync stage or later
	assign cnt_fall    = q.cnt_q & ~q.sync2[cpsel_pkg::IN_CNT];
	assign clr_act     = q.sync2[cpsel_pkg::IN_CLR];
	assign clr_rise    = clr_act & ~q.clr_q;
	assign clr_fall    = ~clr_act & q.clr_q;
	assign release_ok  = q.deb[cpsel_pkg::IN_REL];
	assign strobe_rise = q.deb[cpsel_pkg::IN_STB] & ~q.strobe_q;

	// dead-time distance of output 1: dead units of 1/1024 s times increments per s
	assign dist_prod = q.dead1 * q.ips;
	assign s_tot     = dist_prod[23:cpsel_pkg::DEAD_SHIFT];
	assign eff_ext   = (s_tot >= 14'(q.clr_ext)) ? 8'h00
		: q.clr_ext - s_tot[7:0];

	// one rpm is INC_PER_REV increments per minute
	// widen before the product, a 16-bit product would wrap at high speed
	assign rpm_scaled = 22'(q.ips) * 22'(cpsel_pkg::SEC_PER_MIN);
	assign above_1rpm = rpm_scaled >= 22'(cpsel_pkg::INC_PER_REV);

	// fast method needs no partial compensation and small programs
	assign fast_ok   = ~q.partial & ~q.many_cams;
	// a changeover never starts during a transfer nor before restore
	assign chg_start = ~q.chg_busy & ~q.xfer_busy & q.loaded;

	always_comb
	begin
		next_q = q;
		next_q.nv_we = 1'b0;

		// two-stage synchroniser for every pin
		next_q.sync1 = pins;
		next_q.sync2 = q.sync1;
		next_q.cnt_q = q.sync2[cpsel_pkg::IN_CNT];
		next_q.clr_q = clr_act;

		// debounce: a level must hold for three sample ticks
		if (q.tick_cnt == 17'(P_DEB_CYC - 1))
		begin
			next_q.tick_cnt = 17'h00000;
			for (int i = 0; i < 6; i++)
			begin
				if (q.sync2[i] == q.deb[i])
				begin
					next_q.deb_cnt[i] = 2'h0;
				end
				else if (q.deb_cnt[i] == cpsel_pkg::DEB_STABLE - 2'h1)
				begin
					next_q.deb[i] = q.sync2[i];
					next_q.deb_cnt[i] = 2'h0;
				end
				else
				begin
					next_q.deb_cnt[i] = q.deb_cnt[i] + 2'h1;
				end
			end
		end
		else
		begin
			next_q.tick_cnt = q.tick_cnt + 17'h00001;
		end
		next_q.strobe_q = q.deb[cpsel_pkg::IN_STB];

		// position counter and clear-shift
		if (cnt_fall)
		begin
			next_q.pos = q.pos + 16'h0001;
		end
		if (clr_rise)
		begin
			if (eff_ext == 8'h00)
			begin
				next_q.pos = 16'h0000;
				next_q.waiting = 1'b0;
			end
			else
			begin
				next_q.waiting = 1'b1;
				next_q.remain = eff_ext;
			end
		end
		else if (clr_fall && q.waiting)
		begin
			next_q.pos = 16'h0000;
			next_q.waiting = 1'b0;
		end
		else if (cnt_fall && clr_act && q.waiting)
		begin
			if (q.remain == 8'h00)
			begin
				next_q.pos = 16'h0000;
				next_q.remain = eff_ext;
				next_q.waiting = eff_ext != 8'h00;
			end
			else
			begin
				next_q.remain = q.remain - 8'h01;
			end
		end
		else if (cnt_fall && clr_act && eff_ext == 8'h00)
		begin
			// zero extension keeps the counter at zero while clear lasts
			next_q.pos = 16'h0000;
		end

		// speed: increments counted over one window
		if (q.win_cnt == 27'(P_SPEED_CYC - 1))
		begin
			next_q.win_cnt = 27'h0000000;
			next_q.ips = q.edge_cnt;
			next_q.edge_cnt = {15'h0000, cnt_fall};
		end
		else
		begin
			next_q.win_cnt = q.win_cnt + 27'h0000001;
			if (cnt_fall && q.edge_cnt != 16'hffff)
			begin
				next_q.edge_cnt = q.edge_cnt + 16'h0001;
			end
		end

		// restore the retained program once after reset release
		if (!q.loaded)
		begin
			next_q.act_prog = I_NV_PROG;
			next_q.loaded = 1'b1;
		end

		// changeover timer; fast or slow method, edit penalty on fast
		if (q.chg_busy)
		begin
			if (q.chg_cnt == 27'h0000000)
			begin
				next_q.chg_busy = 1'b0;
				next_q.act_prog = q.pend_prog;
				next_q.nv_we = 1'b1;
				next_q.edited = 1'b0;
			end
			else
			begin
				next_q.chg_cnt = q.chg_cnt - 27'h0000001;
			end
		end
		else if (chg_start && strobe_rise)
		begin
			// sel lines are debounced too, so they settled with the strobe
			next_q.chg_busy = 1'b1;
			next_q.pend_prog = q.deb[3:0];
			if (!fast_ok)
			begin
				next_q.chg_cnt = 27'(P_SLOW_CYC - 1);
			end
			else if (q.edited)
			begin
				next_q.chg_cnt = 27'(P_FAST_CYC + P_EDIT_CYC - 1);
			end
			else
			begin
				next_q.chg_cnt = 27'(P_FAST_CYC - 1);
			end
		end

		// register writes; stored program data gated by release
		next_q.rdata = 32'h00000000;
		if (I_WR)
		begin
			if (I_ADDR == cpsel_pkg::ADDR_CLR_EXT && release_ok)
			begin
				next_q.clr_ext = I_WDATA[7:0];
			end
			else if (I_ADDR == cpsel_pkg::ADDR_DEAD && release_ok)
			begin
				next_q.dead1 = I_WDATA[7:0];
			end
			else if (I_ADDR == cpsel_pkg::ADDR_CAMINFO && release_ok)
			begin
				next_q.cam_mask = I_WDATA[15:0];
				next_q.dead_mask = I_WDATA[31:16];
				next_q.edited = 1'b1;
			end
			else if (I_ADDR == cpsel_pkg::ADDR_CFG)
			begin
				next_q.partial = I_WDATA[cpsel_pkg::CFG_PARTIAL];
				next_q.many_cams = I_WDATA[cpsel_pkg::CFG_MANY];
				next_q.xfer_busy = I_WDATA[cpsel_pkg::CFG_XFER];
			end
			else if (I_ADDR == cpsel_pkg::ADDR_VIEW)
			begin
				next_q.mode = cpsel_pkg::cpsel_mode_e'(I_WDATA[1:0]);
				next_q.show_prog = I_WDATA[cpsel_pkg::VIEW_PROG_LSB +: 4];
				if (I_WDATA[1:0] == cpsel_pkg::MODE_OUTPUT
					&& q.mode != cpsel_pkg::MODE_OUTPUT)
				begin
					next_q.show_out = cpsel_pkg::OUT_RESET;
				end
				else
				begin
					next_q.show_out = I_WDATA[cpsel_pkg::VIEW_OUT_LSB +: 5];
				end
				// keypad change, confirmed in software, obeys the same gate
				if (I_WDATA[cpsel_pkg::VIEW_KP_REQ] && chg_start && !strobe_rise)
				begin
					next_q.chg_busy = 1'b1;
					next_q.pend_prog = I_WDATA[cpsel_pkg::VIEW_PROG_LSB +: 4];
					next_q.chg_cnt = fast_ok ? 27'(P_FAST_CYC - 1)
						: 27'(P_SLOW_CYC - 1);
				end
			end
		end
		else if (I_RD)
		begin
			if (I_ADDR == cpsel_pkg::ADDR_CLR_EXT)
			begin
				next_q.rdata = {16'h0000, eff_ext, q.clr_ext};
			end
			else if (I_ADDR == cpsel_pkg::ADDR_DEAD)
			begin
				next_q.rdata = {24'h000000, q.dead1};
			end
			else if (I_ADDR == cpsel_pkg::ADDR_CAMINFO)
			begin
				next_q.rdata = {q.dead_mask, q.cam_mask};
			end
			else if (I_ADDR == cpsel_pkg::ADDR_CFG)
			begin
				next_q.rdata = {29'h00000000, q.xfer_busy, q.many_cams, q.partial};
			end
			else if (I_ADDR == cpsel_pkg::ADDR_VIEW)
			begin
				next_q.rdata = {19'h00000, q.show_out, q.show_prog, 2'h0, q.mode};
			end
			else if (I_ADDR == cpsel_pkg::ADDR_STATUS)
			begin
				next_q.rdata = {q.pos, 8'h00, q.waiting, release_ok, fast_ok,
					q.chg_busy, q.act_prog};
			end
			else if (I_ADDR == cpsel_pkg::ADDR_SPEED)
			begin
				next_q.rdata = {16'h0000, q.ips};
			end
		end

		// display value and indicators, leds = {n, dp, on/off, func, speed}
		next_q.disp = (q.mode == cpsel_pkg::MODE_NORMAL && above_1rpm)
			? q.ips : q.pos;
		next_q.leds[0] = q.mode == cpsel_pkg::MODE_NORMAL && above_1rpm;
		next_q.leds[4] = q.mode == cpsel_pkg::MODE_NORMAL && above_1rpm;
		next_q.leds[3] = q.mode == cpsel_pkg::MODE_PROG
			&& q.show_prog == q.act_prog;
		next_q.leds[2] = q.mode == cpsel_pkg::MODE_PROG
			&& q.cam_mask[q.show_prog];
		next_q.leds[1] = q.mode == cpsel_pkg::MODE_OUTPUT
			&& q.show_out < 5'h10 && q.dead_mask[q.show_out[3:0]];
	end

	// single state register; constants only under reset
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			q <= '0;
			q.show_out <= cpsel_pkg::OUT_RESET;
			q.clr_ext <= cpsel_pkg::EXT_RESET;
		end
		else
		begin
			q <= next_q;
		end
	end

	assign O_RDATA      = q.rdata;
	assign O_NV_PROG    = q.act_prog;
	assign O_NV_WE      = q.nv_we;
	assign O_ACT_PROG   = q.act_prog;
	assign O_CHG_BUSY   = q.chg_busy;
	assign O_POSITION   = q.pos;
	assign O_DISP_VALUE = q.disp;
	assign O_SHOW_SPEED = q.leds[0];
	assign O_DIGIT2_N   = q.leds[4];
	assign O_DP_MID     = q.leds[3];
	assign O_LED_ON     = q.leds[2];
	assign O_LED_OFF    = q.leds[2];
	assign O_LED_FUNC   = q.leds[1];
	assign O_SHOW_OUT   = q.show_out;
	assign O_EDIT_ENA   = release_ok;

	// checks
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);

	a_release_gate: assert property (I_WR && I_ADDR == cpsel_pkg::ADDR_CLR_EXT
		&& !release_ok |=> $stable(q.clr_ext)) else $error("edit without release");
	a_prog_restore: assert property ($rose(q.loaded) |-> q.act_prog == $past(I_NV_PROG))
		else $error("active program not restored");
	a_speed_shown: assert property (q.mode == cpsel_pkg::MODE_NORMAL && above_1rpm
		|=> O_SHOW_SPEED && O_DIGIT2_N) else $error("speed not shown");
	a_ext_clamp: assert property (s_tot >= 14'(q.clr_ext) |-> eff_ext == 8'h00)
		else $error("extension not clamped");
	a_ext_reduce: assert property (s_tot < 14'(q.clr_ext)
		|-> 14'(eff_ext) + s_tot == 14'(q.clr_ext)) else $error("extension not reduced");
	a_ext_reset: assert property (cnt_fall && clr_act && q.waiting && q.remain == 8'h00
		&& !clr_rise |=> q.pos == 16'h0000 && q.remain == $past(eff_ext))
		else $error("no reset after extension");
	a_early_clear: assert property (clr_fall && q.waiting && !clr_rise
		|=> q.pos == 16'h0000 && !q.waiting) else $error("early clear missed");
	a_zero_ext: assert property (clr_rise && eff_ext == 8'h00 |=> q.pos == 16'h0000)
		else $error("zero extension delayed");
	a_count_edge: assert property (cnt_fall && !clr_act && !q.clr_q
		|=> q.pos == $past(q.pos) + 16'h0001) else $error("count edge lost");
	a_strobe_take: assert property (strobe_rise && chg_start
		|=> q.chg_busy && q.pend_prog == $past(q.deb[3:0])) else $error("strobe ignored");
	a_xfer_block: assert property (q.xfer_busy && !q.chg_busy |=> !q.chg_busy)
		else $error("change during transfer");
	a_chg_bound: assert property ($rose(q.chg_busy) && fast_ok |-> q.chg_cnt
		< 27'(P_FAST_CYC + P_EDIT_CYC)) else $error("changeover too long");
	a_out_default: assert property (q.mode == cpsel_pkg::MODE_OUTPUT
		&& $past(q.mode) != cpsel_pkg::MODE_OUTPUT |-> q.show_out == 5'h01)
		else $error("output selection not at 1");

	c_clear_wait:  cover property (q.waiting ##1 q.pos == 16'h0000 && clr_act);
	c_early_clear: cover property (clr_fall && q.waiting);
	c_prog_change: cover property ($fell(q.chg_busy));
	c_speed_view:  cover property ($rose(O_SHOW_SPEED));
endmodule

/* cpsel_ctrl_model.sv */
// machine controller model: program pins, programming release and encoder pulses
`timescale 1ns/1ps
module cpsel_ctrl_model (
	input  wire logic       clk,   // system clock
	output logic      [3:0] o_sel, // program select lines 8/4/2/1
	output logic            o_stb, // program change strobe
	output logic            o_rel, // programming release
	output logic            o_cnt, // encoder count pulse
	output logic            o_clr  // encoder clear
);
	// all pins low at power-up, like an unpowered 24 V output stage
	initial
	begin
		o_sel = 4'h0;
		o_stb = 1'b0;
		o_rel = 1'b0;
		o_cnt = 1'b0;
		o_clr = 1'b0;
	end
	// number settles first, strobe held far past the debounce time
	task automatic change(input logic [3:0] p);
		@(posedge clk);
		o_sel <= p;
		repeat (20) @(posedge clk);
		o_stb <= 1'b1;
		repeat (40) @(posedge clk); // scaled minimum hold
		o_stb <= 1'b0;
	endtask
	// whole pulses, 6 cycles each; the tail gap lets the last count land
	task automatic pulses(input int n);
		repeat (n)
		begin
			@(posedge clk);
			o_cnt <= 1'b1;
			repeat (3) @(posedge clk);
			o_cnt <= 1'b0;
			repeat (2) @(posedge clk);
		end
		repeat (6) @(posedge clk);
	endtask
	// clear level; callers always send a pulse between its edges
	task automatic clr(input logic v);
		@(posedge clk);
		o_clr <= v;
		repeat (6) @(posedge clk);
	endtask
	// release level, held as long as edits are meant to be allowed
	task automatic rel(input logic v);
		@(posedge clk);
		o_rel <= v;
	endtask
endmodule

/* cpsel_top_tb.sv */
// self-checking bench of the cam program select and clear-shift block
`timescale 1ns/1ps
module cpsel_top_tb;
	typedef struct packed { logic [31:0] e; logic [31:0] m; } cpsel_note_s;
	logic        clk, rst_n, wr_s, rd_s, prb, rd_d, nv_we, busy, spd, dig2, dp, lon, loff, lfn, edit;
	logic [7:0]  addr, r;
	logic [31:0] wdata, rdata;
	logic [3:0]  sel, nv_prog, act;
	logic [4:0]  sh_out;
	logic        dvs;
	logic [15:0] posn, dispv;
	logic [3:0]  nv_in = 4'h9;
	logic [11:0] obs;
	logic [3:0]  pv [4] = '{4'h0, 4'ha, 4'h3, 4'h7};
	int          cv [4] = '{50, 200, 200, 80};
	logic [31:0] fv [4] = '{32'h0, 32'h1, 32'h2, 32'h0};
	cpsel_note_s q_rd[$], q_pb[$], q_cg[$], q_dv[$], nt;
	int          n_mismatch, compares, seed, bcnt, i;
	wire         stb, rel, cnt, clr;

	cpsel_top #(.P_FAST_CYC(50), .P_SLOW_CYC(200), .P_EDIT_CYC(30), .P_DEB_CYC(4),
		.P_SPEED_CYC(100)) uut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_SEL_W8(sel[3]),
		.I_SEL_W4(sel[2]), .I_SEL_W2(sel[1]), .I_SEL_W1(sel[0]), .I_CHG_STROBE(stb),
		.I_PROG_RELEASE(rel), .I_COUNT(cnt), .I_CLEAR(clr), .I_NV_PROG(nv_in),
		.O_NV_PROG(nv_prog), .O_NV_WE(nv_we), .O_ACT_PROG(act), .O_CHG_BUSY(busy),
		.O_POSITION(posn), .O_DISP_VALUE(dispv), .O_SHOW_SPEED(spd), .O_DIGIT2_N(dig2),
		.O_DP_MID(dp), .O_LED_ON(lon), .O_LED_OFF(loff), .O_LED_FUNC(lfn),
		.O_SHOW_OUT(sh_out), .O_EDIT_ENA(edit));
	cpsel_ctrl_model ctl (.clk(clk), .o_sel(sel), .o_stb(stb), .o_rel(rel), .o_cnt(cnt),
		.o_clr(clr));
	// indicator snapshot compared on a probe request
	assign obs = {spd, dig2, dp, lon, loff, lfn, sh_out, edit};

	// free-running 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic miss(input string s);
		$display("Error at %0t: %s", $time, s);
		n_mismatch++;
	endtask

	task automatic end_sim;
		if (q_rd.size() + q_pb.size() + q_cg.size() + q_dv.size() != 0)
			miss("noted results never appeared");
		if (n_mismatch == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		q_rd.push_back('{e, m});
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
	endtask

	task automatic probe(input logic [11:0] e, input logic [11:0] m);
		q_pb.push_back('{{20'h0, e}, {20'h0, m}});
		@(posedge clk);
		prb <= 1'b1;
		@(posedge clk);
		prb <= 1'b0;
	endtask

	// display value and position word compared one cycle later
	task automatic dv(input logic [31:0] e, input logic [31:0] m);
		q_dv.push_back('{e, m});
		@(posedge clk);
		dvs <= 1'b1;
		@(posedge clk);
		dvs <= 1'b0;
	endtask

	task automatic pos(input int n, input logic [15:0] p);
		ctl.pulses(n);
		rd(cpsel_pkg::ADDR_STATUS, {p, 16'h0}, 32'hffff_0000);
	endtask

	// one pin changeover, bounded wait for busy to come and go
	task automatic chg(input logic [3:0] p, input int c);
		bit seen;
		seen = 1'b0;
		q_cg.push_back('{{28'h0, p}, c});
		ctl.change(p);
		for (int k = 0; k < 400 && !(seen && busy === 1'b0); k++)
		begin
			@(posedge clk);
			seen = seen | (busy === 1'b1);
		end
		if (!(seen && busy === 1'b0))
		begin
			miss("changeover did not finish");
			end_sim();
		end
	endtask

	// watcher: each appearing result takes the oldest note of its kind
	always @(posedge clk)
	begin
		rd_d <= rd_s;
		bcnt <= (nv_we === 1'b1) ? 0 : bcnt + int'(busy === 1'b1);
		// retained store: keeps what the block asks to retain
		nv_in <= (nv_we === 1'b1) ? nv_prog : nv_in;
		if (dvs && q_dv.size() > 0)
		begin
			nt = q_dv.pop_front();
			compares++;
			if (({dispv, posn} & nt.m) !== (nt.e & nt.m))
				miss($sformatf("display %h position %h", dispv, posn));
		end
		if (rd_d && q_rd.size() > 0)
		begin
			nt = q_rd.pop_front();
			compares++;
			if ((rdata & nt.m) !== (nt.e & nt.m))
				miss($sformatf("read %h expected %h", rdata, nt.e));
		end
		if (prb && q_pb.size() > 0)
		begin
			nt = q_pb.pop_front();
			compares++;
			if ((obs & nt.m[11:0]) !== (nt.e[11:0] & nt.m[11:0]))
				miss($sformatf("indicators %h expected %h", obs, nt.e[11:0]));
		end
		if (nv_we === 1'b1)
		begin
			compares++;
			if (q_cg.size() == 0)
				miss("unexpected changeover");
			else
			begin
				nt = q_cg.pop_front();
				if (act !== nt.e[3:0] || nv_prog !== nt.e[3:0] || bcnt < int'(nt.m) - 1
					|| bcnt > int'(nt.m) + 2)
					miss($sformatf("program %h after %0d cycles", act, bcnt));
			end
		end
	end

	// main sequence; the model's clear and pulses stand in for the encoder
	initial
	begin
		seed = 13;
		rst_n = 1'b0;
		{wr_s, rd_s, prb, dvs, addr, wdata} = '0;
		{n_mismatch, compares} = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(cpsel_pkg::ADDR_STATUS, 32'h9, 32'hf);
		rd(cpsel_pkg::ADDR_CLR_EXT, 32'h0, 32'hffff_ffff);
		rd(8'h1c, 32'h0, 32'hffff_ffff);
		probe(12'h002, 12'h03f);
		wr(cpsel_pkg::ADDR_CLR_EXT, 32'h5);
		rd(cpsel_pkg::ADDR_CLR_EXT, 32'h0, 32'hff);
		ctl.rel(1'b1);
		repeat (30) @(posedge clk);
		probe(12'h001, 12'h001);
		// random and top boundary of the extension, no dead time yet
		for (i = 0; i < 2; i++)
		begin
			r = i ? 8'hff : 8'($random(seed));
			wr(cpsel_pkg::ADDR_CLR_EXT, {24'h0, r});
			rd(cpsel_pkg::ADDR_CLR_EXT, {16'h0, r, r}, 32'hffff);
		end
		wr(cpsel_pkg::ADDR_CLR_EXT, 32'h3);
		pos(5, 16'd5);
		ctl.clr(1'b1);
		pos(3, 16'd8);
		pos(1, 16'd0);
		pos(3, 16'd3);
		pos(1, 16'd0);
		pos(2, 16'd2);
		ctl.clr(1'b0);
		pos(0, 16'd0);
		wr(cpsel_pkg::ADDR_CLR_EXT, 32'h0);
		pos(2, 16'd2);
		ctl.clr(1'b1);
		pos(0, 16'd0);
		pos(1, 16'd0);
		ctl.clr(1'b0);
		pos(1, 16'd1);
		// 16..17 counts per window at dead 128 cost exactly 2 increments
		wr(cpsel_pkg::ADDR_DEAD, 32'd128);
		for (i = 0; i < 2; i++)
		begin
			wr(cpsel_pkg::ADDR_CLR_EXT, i ? 32'h1 : 32'ha);
			fork
				ctl.pulses(45);
				begin
					repeat (215) @(posedge clk);
					rd(cpsel_pkg::ADDR_CLR_EXT, i ? 32'h1 : 32'h80a, 32'hffff);
					probe(12'hc00, 12'hc00);
					dv(32'h0010_0000, 32'hfffe_0000);
				end
			join
			repeat (250) @(posedge clk);
			probe(12'h000, 12'hc00);
			dv({2{16'(46 + 45 * i)}}, 32'hffff_ffff);
		end
		// fast, partial, many cams, then fast after an edit
		pv[0] = 4'($random(seed));
		if (pv[0] == 4'h9)
			pv[0] = 4'h1;
		for (i = 0; i < 4; i++)
		begin
			if (i == 3)
				wr(cpsel_pkg::ADDR_CAMINFO, 32'h0002_0080);
			wr(cpsel_pkg::ADDR_CFG, fv[i]);
			chg(pv[i], cv[i]);
		end
		// strobe during a transfer must be dropped
		wr(cpsel_pkg::ADDR_CFG, 32'h4);
		ctl.change(4'h2);
		repeat (100) @(posedge clk);
		rd(cpsel_pkg::ADDR_STATUS, 32'h7, 32'h1f);
		wr(cpsel_pkg::ADDR_CFG, 32'h0);
		wr(cpsel_pkg::ADDR_VIEW, 32'h71);
		probe(12'h380, 12'h380);
		wr(cpsel_pkg::ADDR_VIEW, 32'h31);
		probe(12'h000, 12'h380);
		wr(cpsel_pkg::ADDR_VIEW, 32'h502);
		probe(12'h042, 12'h07e);
		// keypad change, then power loss: the retained program comes back
		q_cg.push_back('{32'h5, 32'd50});
		wr(cpsel_pkg::ADDR_VIEW, 32'h54);
		repeat (60) @(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(cpsel_pkg::ADDR_STATUS, 32'h5, 32'h1f);
		probe(12'h002, 12'h03f);
		repeat (5) @(posedge clk);
		end_sim();
	end
endmodule
